// *** core/tps_core.sv ***
// Prescalers, count clock selection and register slave for three timers.
// Assumes Avalon-MM master holding each request until waitrequest is low.
`include "tps_cfg.svh"
module tps_core #(
  parameter int PRESC_W = `TPS_PRESC_W
) (
  input  wire logic             sys_clk,
  input  wire logic             rst_b,
  input  wire logic [9:0]       avs_address,
  input  wire logic             avs_read,
  input  wire logic             avs_write,
  input  wire logic [31:0]      avs_writedata,
  input  wire logic [3:0]       avs_byteenable,
  output logic      [31:0]      avs_readdata,
  output logic                  avs_waitrequest,
  input  wire tps_pkg::tps_csel_t count_clock_select,
  input  wire logic [2:0]       external_count_pins,
  output logic      [2:0]       count_tick,
  output logic      [1:0]       timer_fast_clk
);
  // -----------------------------------------------------------------
  // Elaboration check
  // -----------------------------------------------------------------
  if (PRESC_W != `TPS_PRESC_W) begin : g_chk
    $error("prescaler width must be ten");
  end

  tps_pkg::tps_state_t s_reg;
  tps_pkg::tps_state_t s_next;
  logic                req;
  logic                wr;
  logic                hit_gtc;
  logic                hit_pss;
  logic                hit_tck;
  logic [7:0]          wd;
  logic [2:0]          cs [3];
  logic [PRESC_W-1:0]  src [3];

  // Divided tick of a prescaler count for one select code.
  function automatic logic tap(input logic [PRESC_W-1:0] c, input logic [2:0] sel);
    logic t;
    t = 1'b0;
    unique case (sel)
      `TPS_CS_SYS:  t = 1'b1;
      `TPS_CS_D8:   t = &c[2:0]; // see [RULE_08]
      `TPS_CS_D64:  t = &c[5:0];
      `TPS_CS_D256: t = &c[7:0];
      `TPS_CS_D1K:  t = &c[9:0];
      default:      t = 1'b0;
    endcase
    return t;
  endfunction : tap

  // -----------------------------------------------------------------
  // Bus decode
  // -----------------------------------------------------------------
  assign req     = avs_read | avs_write;
  assign hit_gtc = (avs_address == {`TPS_IDX_GTC, 2'b00});
  assign hit_pss = (avs_address == {`TPS_IDX_PSS, 2'b00});
  assign hit_tck = (avs_address == {`TPS_IDX_TCK, 2'b00});
  assign wd      = avs_writedata[7:0];
  assign wr      = avs_write & s_reg.ack & avs_byteenable[0];
  assign avs_waitrequest = req & ~s_reg.ack;
  assign avs_readdata    = {24'h000000, s_reg.rdata};
  assign count_tick      = s_reg.tick;
  assign timer_fast_clk  = s_reg.fflag;

  assign cs[0] = count_clock_select.t0;
  assign cs[1] = count_clock_select.t1;
  assign cs[2] = count_clock_select.t3;

  // Prescaler feeding each timer.
  assign src[0] = s_reg.pc; // see [RULE_03]
  assign src[1] = s_reg.own_prescaler_sel_t1 ? s_reg.p1 : s_reg.pc; // see [RULE_04]
  assign src[2] = s_reg.own_prescaler_sel_t3 ? s_reg.p3 : s_reg.pc; // see [RULE_05]

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    s_next.ack = req & ~s_reg.ack;
    // Reset bits stay set only while the sync hold is on.
    s_next.psr_c = s_reg.timer_sync_hold & s_reg.psr_c; // see [RULE_15]
    s_next.private_prescaler_reset_t1  = s_reg.timer_sync_hold & s_reg.private_prescaler_reset_t1 & s_reg.own_prescaler_sel_t1;
    s_next.private_prescaler_reset_t3  = s_reg.timer_sync_hold & s_reg.private_prescaler_reset_t3 & s_reg.own_prescaler_sel_t3;
    if (wr && hit_gtc) begin
      s_next.timer_sync_hold = wd[`TPS_GTC_SYNC];
      // A written one wins over the hardware clear.
      if (wd[`TPS_GTC_PSRC]) begin
        s_next.psr_c = 1'b1; // see [RULE_14]
      end
    end
    if (wr && hit_pss) begin
      s_next.own_prescaler_sel_t1 = wd[`TPS_PSS_SEL1];
      s_next.own_prescaler_sel_t3 = wd[`TPS_PSS_SEL3];
      if (wd[`TPS_PSS_PRIVATE_PRESCALER_RESET_T1] && s_reg.own_prescaler_sel_t1) begin
        s_next.private_prescaler_reset_t1 = 1'b1; // see [RULE_12]
      end
      if (wd[`TPS_PSS_PRIVATE_PRESCALER_RESET_T3] && s_reg.own_prescaler_sel_t3) begin
        s_next.private_prescaler_reset_t3 = 1'b1; // see [RULE_13]
      end
    end
    if (wr && hit_tck) begin
      // Timer three has no fast select, so it can only run from the system clock.
      s_next.fsel = {wd[`TPS_TCK_SEL1], wd[`TPS_TCK_SEL0]}; // see [RULE_07]
    end
    // Flag follows the select once the switch has taken effect.
    s_next.fflag = s_reg.fsel; // see [RULE_01] [RULE_20]
    // Free running counters, cleared by their reset terms.
    s_next.pc = s_reg.psr_c ? '0 : s_reg.pc + 1'b1; // see [RULE_09] [RULE_10] [RULE_02]
    s_next.p1 = (!s_reg.own_prescaler_sel_t1 || s_reg.private_prescaler_reset_t1) ? '0 : s_reg.p1 + 1'b1; // see [RULE_11] [RULE_06]
    s_next.p3 = (!s_reg.own_prescaler_sel_t3 || s_reg.private_prescaler_reset_t3) ? '0 : s_reg.p3 + 1'b1; // see [RULE_11] [RULE_06]
    // External pins: two sync stages then an edge stage.
    s_next.s1   = external_count_pins;
    s_next.s2   = s_reg.s1;
    s_next.prev = s_reg.s2;
    for (int i = 0; i < 3; i++) begin
      unique case (cs[i])
        `TPS_CS_FALL: s_next.tick[i] = ~s_reg.s2[i] & s_reg.prev[i]; // see [RULE_16]
        `TPS_CS_RISE: s_next.tick[i] = s_reg.s2[i] & ~s_reg.prev[i]; // see [RULE_17]
        default:      s_next.tick[i] = tap(src[i], cs[i]);
      endcase
    end
    s_next.rdata = 8'h00;
    if (avs_read && !s_reg.ack) begin
      if (hit_gtc) begin
        s_next.rdata[`TPS_GTC_SYNC] = s_reg.timer_sync_hold;
      end
      if (hit_pss) begin
        s_next.rdata[`TPS_PSS_SEL1] = s_reg.own_prescaler_sel_t1;
        s_next.rdata[`TPS_PSS_SEL3] = s_reg.own_prescaler_sel_t3;
      end
      if (hit_tck) begin
        s_next.rdata[`TPS_TCK_FLG1] = s_reg.fflag[1];
        s_next.rdata[`TPS_TCK_FLG0] = s_reg.fflag[0];
        s_next.rdata[`TPS_TCK_SEL1] = s_reg.fsel[1];
        s_next.rdata[`TPS_TCK_SEL0] = s_reg.fsel[0];
      end
    end
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // -----------------------------------------------------------------
  // Assertions
  // -----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence pin0_rise;
    !external_count_pins[0] ##1 external_count_pins[0];
  endsequence

  sequence pin0_held;
    (external_count_pins[0] && cs[0] == `TPS_CS_RISE)[*2];
  endsequence

  bus_answer_a: assert property (avs_waitrequest |=> !avs_waitrequest) // see [RULE_12]
    else $error("waitrequest held more than one cycle");

  sync_hold_a: assert property (s_reg.psr_c && !s_reg.timer_sync_hold && !wr |=> !s_reg.psr_c) // see [RULE_15]
    else $error("common reset bit not cleared");

  private_hold_a: assert property (!s_reg.own_prescaler_sel_t1 |=> s_reg.p1 == '0) // see [RULE_11]
    else $error("unselected private prescaler running");

  common_reset_a: assert property (s_reg.psr_c |=> s_reg.pc == '0) // see [RULE_14]
    else $error("common prescaler not reset");

  free_run_a: assert property (!s_reg.psr_c |=> s_reg.pc == $past(s_reg.pc) + 1'b1) // see [RULE_09]
    else $error("common prescaler not counting");

  div_eight_a: assert property ((cs[0] == `TPS_CS_D8 && s_reg.pc[2:0] == 3'h7 && !s_reg.psr_c)
    |=> count_tick[0]) // see [RULE_08]
    else $error("divide by eight tick missing");

  own_presc_a: assert property ((s_reg.own_prescaler_sel_t1 && cs[1] == `TPS_CS_D8 && s_reg.p1[2:0] == 3'h7)
    |=> count_tick[1]) // see [RULE_04]
    else $error("timer one private tick missing");

  ext_edge_a: assert property ((cs[0] == `TPS_CS_RISE && s_reg.s2[0] && !s_reg.prev[0])
    |=> count_tick[0]) // see [RULE_16]
    else $error("rising edge tick missing");

  ext_latency_a: assert property (pin0_rise ##1 pin0_held |=> count_tick[0]) // see [RULE_17]
    else $error("external edge latency wrong");

  fast_flag_a: assert property ((wr && hit_tck && wd[`TPS_TCK_SEL1]) |=> ##1 timer_fast_clk[1]) // see [RULE_01]
    else $error("fast clock flag not set");

  reset_read_a: assert property ((avs_read && hit_pss && !avs_waitrequest)
    |-> avs_readdata[1:0] == 2'b00) // see [RULE_13]
    else $error("reset bits read nonzero");

  // -----------------------------------------------------------------
  // Private prescaler checks
  // -----------------------------------------------------------------
  private_hold3_a: assert property ( // see [RULE_11]
    !s_reg.own_prescaler_sel_t3
    |=> s_reg.p3 == '0)
    else $error("unselected timer three prescaler running");

  own_presc3_a: assert property ( // see [RULE_05]
    (s_reg.own_prescaler_sel_t3 && cs[2] == `TPS_CS_D8 && s_reg.p3[2:0] == 3'h7)
    |=> count_tick[2])
    else $error("timer three private tick missing");

  private_reset1_a: assert property ( // see [RULE_06]
    s_reg.private_prescaler_reset_t1
    |=> s_reg.p1 == '0)
    else $error("timer one prescaler not reset");

  private_reset3_a: assert property ( // see [RULE_06]
    s_reg.private_prescaler_reset_t3
    |=> s_reg.p3 == '0)
    else $error("timer three prescaler not reset");

  reset_isolated_a: assert property ( // see [RULE_06]
    (s_reg.psr_c && s_reg.own_prescaler_sel_t1 && !s_reg.private_prescaler_reset_t1)
    |=> s_reg.p1 == $past(s_reg.p1) + 1'b1)
    else $error("common reset reached timer one prescaler");

  // -----------------------------------------------------------------
  // Shared prescaler and tap checks
  // -----------------------------------------------------------------
  shared_t1_a: assert property ( // see [RULE_03]
    (!s_reg.own_prescaler_sel_t1 && cs[1] == `TPS_CS_D8 && s_reg.pc[2:0] == 3'h7)
    |=> count_tick[1])
    else $error("timer one shared tick missing");

  shared_t3_a: assert property ( // see [RULE_03]
    (!s_reg.own_prescaler_sel_t3 && cs[2] == `TPS_CS_D8 && s_reg.pc[2:0] == 3'h7)
    |=> count_tick[2])
    else $error("timer three shared tick missing");

  shared_reset1_a: assert property ( // see [RULE_10]
    (s_reg.psr_c && !s_reg.own_prescaler_sel_t1) ##1 (cs[1] == `TPS_CS_D8)
    |=> !count_tick[1])
    else $error("shared reset did not restart timer one");

  shared_reset3_a: assert property ( // see [RULE_10]
    (s_reg.psr_c && !s_reg.own_prescaler_sel_t3) ##1 (cs[2] == `TPS_CS_D8)
    |=> !count_tick[2])
    else $error("shared reset did not restart timer three");

  div_full_a: assert property ( // see [RULE_02]
    (cs[0] == `TPS_CS_D1K && s_reg.pc == '1)
    |=> count_tick[0])
    else $error("divide by 1024 tick missing");

  sys_tick_a: assert property ( // see [RULE_07]
    cs[2] == `TPS_CS_SYS
    |=> count_tick[2])
    else $error("timer three system clock tick missing");

  stop_tick_a: assert property ( // see [RULE_08]
    cs[0] == `TPS_CS_STOP
    |=> !count_tick[0])
    else $error("stopped timer received a tick");

  // -----------------------------------------------------------------
  // Reset bit checks
  // -----------------------------------------------------------------
  // The private reset bits must not stick when the sync hold is off.
  private_prescaler_reset_t1_clear_a: assert property ( // see [RULE_12]
    (s_reg.private_prescaler_reset_t1 && !s_reg.timer_sync_hold && !wr)
    |=> !s_reg.private_prescaler_reset_t1)
    else $error("timer one reset bit not cleared");

  private_prescaler_reset_t3_clear_a: assert property ( // see [RULE_13]
    (s_reg.private_prescaler_reset_t3 && !s_reg.timer_sync_hold && !wr)
    |=> !s_reg.private_prescaler_reset_t3)
    else $error("timer three reset bit not cleared");

  private_prescaler_reset_t1_reject_a: assert property ( // see [RULE_12]
    (wr && hit_pss && wd[`TPS_PSS_PRIVATE_PRESCALER_RESET_T1] && !s_reg.own_prescaler_sel_t1)
    |=> !s_reg.private_prescaler_reset_t1)
    else $error("timer one reset accepted while shared");

  private_prescaler_reset_t3_reject_a: assert property ( // see [RULE_13]
    (wr && hit_pss && wd[`TPS_PSS_PRIVATE_PRESCALER_RESET_T3] && !s_reg.own_prescaler_sel_t3)
    |=> !s_reg.private_prescaler_reset_t3)
    else $error("timer three reset accepted while shared");

  hold_keep_a: assert property ( // see [RULE_15]
    (s_reg.psr_c && s_reg.timer_sync_hold)
    |=> s_reg.psr_c)
    else $error("common reset released under sync hold");

  gtc_read_a: assert property ( // see [RULE_14]
    (avs_read && hit_gtc && !avs_waitrequest)
    |-> avs_readdata[0] == 1'b0)
    else $error("common reset bit read nonzero");

  tsm_read_a: assert property ( // see [RULE_15]
    (avs_read && hit_gtc && avs_waitrequest)
    |=> avs_readdata[7] == $past(s_reg.timer_sync_hold))
    else $error("sync hold readback wrong");

  // -----------------------------------------------------------------
  // Fast clock and external pin checks
  // -----------------------------------------------------------------
  fast_follow_a: assert property ( // see [RULE_20]
    1'b1
    |=> timer_fast_clk == $past(s_reg.fsel))
    else $error("fast flag does not follow select");

  tck_read_a: assert property ( // see [RULE_20]
    (avs_read && hit_tck && avs_waitrequest)
    |=> avs_readdata[5:4] == $past(s_reg.fflag))
    else $error("fast flag readback wrong");

  ext_fall_a: assert property ( // see [RULE_16]
    (cs[1] == `TPS_CS_FALL && !s_reg.s2[1] && s_reg.prev[1])
    |=> count_tick[1])
    else $error("falling edge tick missing");
endmodule : tps_core

// *** core/tps_cfg.svh ***
// Offsets, field positions, reset values and select codes of the timer prescaler block.
// Assumes inclusion by the package, the core module and the bench.
// Function
// [RULE_01] see timer one fast flag drives doubled clock
// [RULE_02] three ten-bit prescaler counters
// [RULE_03] both selects zero: all share common
// [RULE_04] select one only: timer one private
// [RULE_05] select three only: timer three private
// [RULE_06] both selects: each private, separate resets
// [RULE_07] timer three never uses fast clock
// [RULE_08] taps divide by 8, 64, 256, 1024
// [RULE_09] prescalers run free of clock selection
// [RULE_10] reset restarts all timers on prescaler
// [RULE_11] unselected private prescaler held in reset
// [RULE_12] timer one reset bit self clears, reads 0
// [RULE_13] timer three reset bit self clears, reads 0
// [RULE_14] common reset bit, always reads 0
// [RULE_15] sync hold keeps reset bits set
// [RULE_16] external pin synchronised, select 7 rise, 6 fall
// [RULE_17] pin change counts after 2.5 to 3.5 clocks
// [RULE_18] software switches external clock on stable pin
// [RULE_19] external pulses wider than one clock
// [RULE_20] flag shows timer one really runs fast
`ifndef TPS_CFG_SVH
`define TPS_CFG_SVH
// -----------------------------------------------------------------
// Register indices, byte address is four times the index
// -----------------------------------------------------------------
`define TPS_IDX_GTC 8'h43
`define TPS_IDX_PSS 8'hE2
`define TPS_IDX_TCK 8'hEC
`define TPS_RST_VAL 8'h00
// -----------------------------------------------------------------
// Field positions
// -----------------------------------------------------------------
`define TPS_GTC_SYNC 7
`define TPS_GTC_PSRC 0
`define TPS_PSS_SEL1 7
`define TPS_PSS_SEL3 6
`define TPS_PSS_PRIVATE_PRESCALER_RESET_T3 1
`define TPS_PSS_PRIVATE_PRESCALER_RESET_T1 0
`define TPS_TCK_FLG1 5
`define TPS_TCK_FLG0 4
`define TPS_TCK_SEL1 1
`define TPS_TCK_SEL0 0
// -----------------------------------------------------------------
// Count clock select codes and prescaler width
// -----------------------------------------------------------------
`define TPS_CS_STOP 3'h0
`define TPS_CS_SYS  3'h1
`define TPS_CS_D8   3'h2
`define TPS_CS_D64  3'h3
`define TPS_CS_D256 3'h4
`define TPS_CS_D1K  3'h5
`define TPS_CS_FALL 3'h6
`define TPS_CS_RISE 3'h7
`define TPS_PRESC_W 10
`endif

// *** core/tps_pkg.sv ***
// Types shared by the timer prescaler block.
// Assumes tps_cfg.svh for the widths.
`include "tps_cfg.svh"
package tps_pkg;
  // Per-timer triple, index 0 timer zero, 1 timer one, 2 timer three.
  typedef struct packed {
    logic [2:0] t3;
    logic [2:0] t1;
    logic [2:0] t0;
  } tps_csel_t;

  typedef struct packed {
    logic                    ack;
    logic [7:0]              rdata;
    logic                    timer_sync_hold;
    logic                    psr_c;
    logic                    own_prescaler_sel_t1;
    logic                    own_prescaler_sel_t3;
    logic                    private_prescaler_reset_t1;
    logic                    private_prescaler_reset_t3;
    logic [1:0]              fsel;
    logic [1:0]              fflag;
    logic [`TPS_PRESC_W-1:0] pc;
    logic [`TPS_PRESC_W-1:0] p1;
    logic [`TPS_PRESC_W-1:0] p3;
    logic [2:0]              s1;
    logic [2:0]              s2;
    logic [2:0]              prev;
    logic [2:0]              tick;
  } tps_state_t;
endpackage : tps_pkg

// *** sim/tps_timer_model.sv ***
// Far-side model: three timer cores that count the ticks they receive.
// Assumes count_tick is synchronous to sys_clk, bit 2 feeding timer three.
module tps_timer_model (
  input  wire logic        sys_clk,
  input  wire logic        rst_b,
  input  wire logic [2:0]  count_tick,
  output logic      [15:0] tick_cnt [3]
);
  // A steady-high tick counts on every clock, as a timer on the system clock would.
  always_ff @(posedge sys_clk) begin
    for (int i = 0; i < 3; i++) begin
      if (!rst_b) begin
        tick_cnt[i] <= 16'h0000;
      end else if (count_tick[i]) begin
        tick_cnt[i] <= tick_cnt[i] + 16'h0001;
      end
    end
  end
endmodule : tps_timer_model

// *** sim/tps_core_tb.sv ***
// Self-checking bench of the timer prescaler block over its Avalon-MM slave.
// Assumes tps_cfg.svh, tps_pkg and tps_core compiled before it.
`include "tps_cfg.svh"
module tps_core_tb;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [9:0] A_GTC = {`TPS_IDX_GTC, 2'b00};
  localparam logic [9:0] A_PSS = {`TPS_IDX_PSS, 2'b00};
  localparam logic [9:0] A_TCK = {`TPS_IDX_TCK, 2'b00};
  logic               sys_clk, rst_b, avs_read, avs_write, avs_waitrequest;
  logic [9:0]         avs_address;
  logic [31:0]        avs_writedata, avs_readdata;
  logic [3:0]         avs_byteenable;
  tps_pkg::tps_csel_t sel;
  logic [2:0]         pins, tick;
  logic [1:0]         fast;
  logic [15:0]        cnt [3];
  logic [15:0]        base [3];
  logic [7:0]         q;
  int                 n_mismatch, n_checks, cyc;
  logic [15:0]        tap_exp [6] = '{16'h0000, 16'h0400, 16'h0080, 16'h0010, 16'h0004, 16'h0001};
  logic [7:0]         pss_v [4] = '{8'h00, 8'h80, 8'h40, 8'hC0};

  tps_core dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .count_clock_select(sel),
    .external_count_pins(pins), .count_tick(tick), .timer_fast_clk(fast));
  tps_timer_model far_u (.sys_clk(sys_clk), .rst_b(rst_b), .count_tick(tick), .tick_cnt(cnt));

  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end

  // ----
  // Bus and comparison tasks
  // ----
  task check(input logic [15:0] got, input logic [15:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t got %h exp %h", $time, got, exp);
    end
  endtask : check

  // Starts one edge later so that a release and a new request never share a time step.
  task bus(input logic [9:0] a, input logic w, input logic [7:0] d);
    @(posedge sys_clk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= {24'h000000, d};
    do begin
      @(posedge sys_clk);
    end while (avs_waitrequest);
    q = avs_readdata[7:0];
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask : bus

  task rd_chk(input logic [9:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    check({8'h00, q}, {8'h00, e});
  endtask : rd_chk

  // Any phase of a divider whose period divides 1024 gives 1024/N ticks in 1024 clocks.
  task win(input logic [15:0] e0, input logic [15:0] e1, input logic [15:0] e3);
    repeat (4) @(negedge sys_clk);
    base = cnt;
    repeat (1024) @(negedge sys_clk);
    check(cnt[0] - base[0], e0);
    check(cnt[1] - base[1], e1);
    check(cnt[2] - base[2], e3);
  endtask : win

  task report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : report_and_stop

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      n_mismatch++;
      report_and_stop();
    end
  end

  initial begin
    rst_b = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 10'h000;
    avs_writedata = 32'h00000000;
    avs_byteenable = 4'hF;
    sel = 9'h000;
    pins = 3'h0;
    repeat (2) @(posedge sys_clk);
    rst_b <= 1'b1;
    foreach (pss_v[i]) rd_chk(i == 3 ? 10'h000 : i == 2 ? A_TCK : i == 1 ? A_PSS : A_GTC, 8'h00);
    bus(10'h3FC, 1'b1, 8'hFF);
    rd_chk(10'h3FC, 8'h00);
    $display("test registers done");
    for (int i = 0; i < 6; i++) begin
      @(posedge sys_clk);
      sel <= tps_pkg::tps_csel_t'({3{i[2:0]}});
      win(tap_exp[i], tap_exp[i], tap_exp[i]);
    end
    $display("test taps done");
    @(posedge sys_clk);
    sel <= tps_pkg::tps_csel_t'({3{`TPS_CS_D8}});
    foreach (pss_v[i]) begin
      bus(A_PSS, 1'b1, pss_v[i]);
      bus(A_GTC, 1'b1, 8'h81);
      rd_chk(A_GTC, 8'h80);
      win(16'h0000, pss_v[i][7] ? 16'h0080 : 16'h0000, pss_v[i][6] ? 16'h0080 : 16'h0000);
      bus(A_GTC, 1'b1, 8'h00);
    end
    bus(A_GTC, 1'b1, 8'h80);
    bus(A_PSS, 1'b1, 8'hC3);
    rd_chk(A_PSS, 8'hC0);
    win(16'h0080, 16'h0000, 16'h0000);
    bus(A_GTC, 1'b1, 8'h00);
    win(16'h0080, 16'h0080, 16'h0080);
    $display("test prescaler modes done");
    bus(A_TCK, 1'b1, 8'hFF);
    rd_chk(A_TCK, 8'h33);
    check({14'h0000, fast}, 16'h0003);
    bus(A_TCK, 1'b1, 8'h01);
    avs_byteenable <= 4'hE;
    bus(A_TCK, 1'b1, 8'h00);
    avs_byteenable <= 4'hF;
    rd_chk(A_TCK, 8'h11);
    check({14'h0000, fast}, 16'h0001);
    $display("test fast clock done");
    @(posedge sys_clk);
    // The pins have been low for many clocks when the edge selects switch on.
    sel <= tps_pkg::tps_csel_t'({3'h7, 3'h6, 3'h7});
    repeat (4) @(negedge sys_clk);
    base = cnt;
    // Pulses of four clocks keep the source well below half the system clock.
    repeat (10) begin
      @(posedge sys_clk);
      pins <= 3'h7;
      repeat (4) @(posedge sys_clk);
      pins <= 3'h0;
      repeat (3) @(posedge sys_clk);
    end
    repeat (8) @(negedge sys_clk);
    for (int i = 0; i < 3; i++) check(cnt[i] - base[i], 16'h000A);
    $display("test external pins done");
    report_and_stop();
  end
endmodule : tps_core_tb
